//--- trace_debug_pkg.sv
// constants, enumerations and carriers for the trace debug control block
package trace_debug_pkg;
  localparam int          ADDR_W      = 12;     // apb byte address width
  localparam int          DATA_W      = 32;     // apb data width
  localparam int          CTRL_W      = 8;      // control register width
  localparam int          BUS_ADDR_W  = 16;     // traced bus address width
  localparam logic [11:0] CTRL_OFFSET = 12'h020; // control register address
  localparam logic [7:0]  CTRL_RESET  = 8'h00;  // control reset value
  localparam int          EN_BIT      = 7;      // trace mode enable
  localparam int          ARM_BIT     = 6;      // arm
  localparam int          TRG_BIT     = 5;      // trigger kind select
  localparam int          BEGIN_BIT   = 4;      // begin/end storing
  localparam int          BRK_BIT     = 3;      // cpu break request enable
  localparam int          CAP_HI      = 1;      // capture mode msb
  localparam int          CAP_LO      = 0;      // capture mode lsb
  localparam logic [7:0]  ARMED_MASK  = 8'hc0;  // bits writable while armed
  localparam logic [7:0]  DEFINED_MASK = 8'hfb; // bit 2 never stores

  // capture mode encodings
  typedef enum logic [1:0] {
    CAP_NORMAL  = 2'b00,
    CAP_DEDUP   = 2'b01,
    CAP_DETAIL  = 2'b10,
    CAP_PROFILE = 2'b11
  } capture_mode_t;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } apb_rsp_t;

  // effective control view for the trace logic
  typedef struct packed {
    logic          traceActive;
    logic          armed;
    logic          taggedTrigger;
    logic          beginStore;
    logic          breakEnable;
    capture_mode_t captureMode;
  } ctrl_view_t;
endpackage

//--- trace_debug_control_reg.sv
// trace debug control register with capture qualification and break
`timescale 1ns/1ns
// Behaviour
// RULE_01: bits act only in trace debug mode; otherRegsLocked still follows bit 6 in legacy mode
// RULE_02: writes ignored while legacy breakpoint enabled
// RULE_03: bit 7 enables trace debug mode
// RULE_04: enable cannot be set in secure mode
// RULE_05: bit 6 arms comparators and storage
// RULE_06: arm sets only with enable set
// RULE_07: bit 5 selects match or tagged trigger
// RULE_08: bit 5 also picks break kind
// RULE_09: bit 4 begin or end storage
// RULE_10: bit 3 enables break at session end
// RULE_11: bits 1:0 select capture mode
// RULE_12: dedup mode blocks repeated entries
// RULE_13: detail mode stores all but fetch/free
// RULE_14: profile returns last executed address
// RULE_15: while armed only enable/arm writable
// RULE_16: arming clears the trace word count
// RULE_17: bit 2 reads zero, ignores writes
module trace_debug_control_reg
  import trace_debug_pkg::*;
(
  input  wire logic                  clk_sys,        // system bus clock
  input  wire logic                  rst,            // async, active high
  input  wire apb_req_t              apbReq,         // apb request
  output apb_rsp_t                   apbRsp,         // apb answer
  input  wire logic                  legacyBreakpointEnable, // from ctrl 2
  input  wire logic                  secureMode,     // chip is secured
  input  wire logic                  sessionDone,    // tracing session end
  input  wire logic                  busValid,       // a bus cycle occurs
  input  wire logic                  busIsFetch,     // program fetch cycle
  input  wire logic                  busIsFree,      // free cycle
  input  wire logic                  busIsFlow,      // change-of-flow fetch
  input  wire logic [BUS_ADDR_W-1:0] busAddr,        // bus cycle address
  input  wire logic                  retireValid,    // instruction executed
  input  wire logic [BUS_ADDR_W-1:0] retireAddr,     // its address
  output ctrl_view_t                 ctrlView,       // effective controls
  output logic                       otherRegsLocked, // lock for other regs
  output logic                       countClear,     // clear word count
  output logic                       storeWrite,     // write capture entry
  output logic [BUS_ADDR_W-1:0]      storeAddr,      // entry address
  output logic [BUS_ADDR_W-1:0]      profileAddr,    // last executed addr
  output logic                       cpuBreakRequest, // break pulse
  output logic                       breakTagged     // break kind
);

  // ---------------- register bus ----------------
  logic [CTRL_W-1:0] ctrl_ff;        // stored control bits
  logic [CTRL_W-1:0] nxt_ctrl;       // next control bits
  logic              countClear_ff;  // registered count clear pulse
  logic              nxt_countClear; // next count clear
  logic [DATA_W-1:0] rdata_ff;       // registered read data
  logic [DATA_W-1:0] nxt_rdata;      // next read data
  logic              setupRd;        // read setup cycle
  logic              hitCtrl;        // address decodes to the register
  logic              wrAccess;       // write access phase
  logic              wrAllowed;      // write not blocked
  logic [CTRL_W-1:0] wbyte;          // written byte
  logic [CTRL_W-1:0] merged;         // written byte after masking
  logic              wantEn;         // enable after secure check
  logic              wantArm;        // arm after enable check

  // decode the address and pick out the two bus phases that matter
  assign hitCtrl  = (apbReq.paddr == CTRL_OFFSET);
  assign wrAccess = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign setupRd  = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
  assign wbyte    = apbReq.pwdata[CTRL_W-1:0];
  // a blocked write still completes on the bus without an error, so
  // software must read back to learn that the legacy mode refused it
  assign wrAllowed = wrAccess && hitCtrl
                  && !legacyBreakpointEnable; // [RULE_02]

  // zero wait state; unmapped addresses answer with an error
  // pready is tied high: every access finishes in its first access cycle
  always_comb begin
    apbRsp.pready  = 1'b1;
    apbRsp.pslverr = apbReq.psel && apbReq.penable && !hitCtrl;
    apbRsp.prdata  = rdata_ff;
  end

  // next control value and side effects of a write
  always_comb begin
    nxt_ctrl       = ctrl_ff;
    nxt_countClear = 1'b0;
    // secure mode and a lone arm both fall back to a cleared bit
    wantEn = wbyte[EN_BIT] && !secureMode;            // [RULE_03] [RULE_04]
    wantArm = wbyte[ARM_BIT] && wantEn;               // [RULE_06]
    merged = wbyte & DEFINED_MASK;                    // [RULE_17]
    merged[EN_BIT]  = wantEn;
    merged[ARM_BIT] = wantArm;
    if (ctrl_ff[ARM_BIT]) begin
      // armed: keep every bit but enable and arm
      merged = (merged & ARMED_MASK)
             | (ctrl_ff & ~ARMED_MASK);               // [RULE_15]
    end
    // an armed session stays open until it ends or software disarms it
    if (sessionDone) begin
      // a finished session disarms the debugger
      nxt_ctrl[ARM_BIT] = 1'b0;
    end
    if (wrAllowed) begin
      // a software write wins over the hardware disarm
      nxt_ctrl = merged;
      nxt_countClear = wantArm;                        // [RULE_16]
    end
  end

  // read data is latched in the setup cycle for a flopped prdata
  // this keeps the bus output glitch free at no cost in wait states
  always_comb begin
    nxt_rdata = '0;
    if (setupRd && hitCtrl) begin
      nxt_rdata[CTRL_W-1:0] = ctrl_ff & DEFINED_MASK;  // [RULE_17]
    end
  end

  // register the bus state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_ff       <= CTRL_RESET;
      countClear_ff <= 1'b0;
      rdata_ff      <= '0;
    end else begin
      ctrl_ff       <= nxt_ctrl;
      countClear_ff <= nxt_countClear;
      rdata_ff      <= nxt_rdata;
    end
  end

  // ---------------- effective controls ----------------
  logic active; // trace mode in use, not legacy mode
  assign active = ctrl_ff[EN_BIT] && !legacyBreakpointEnable; // [RULE_01]

  // every field is held off outside trace debug mode
  always_comb begin
    ctrlView.traceActive   = active;                           // [RULE_03]
    ctrlView.armed         = active && ctrl_ff[ARM_BIT];       // [RULE_05]
    ctrlView.taggedTrigger = active && ctrl_ff[TRG_BIT];       // [RULE_07]
    ctrlView.beginStore    = active && ctrl_ff[BEGIN_BIT];     // [RULE_09]
    ctrlView.breakEnable   = active && ctrl_ff[BRK_BIT];       // [RULE_10]
    ctrlView.captureMode   = active
      ? capture_mode_t'(ctrl_ff[CAP_HI:CAP_LO]) : CAP_NORMAL;  // [RULE_11]
  end

  // gating every field here keeps the capture qualification free of mode checks; the profile update tests active itself
  assign otherRegsLocked = ctrl_ff[ARM_BIT];                   // [RULE_15]
  assign countClear      = countClear_ff;
  assign breakTagged     = ctrlView.breakEnable
                        && ctrlView.taggedTrigger;             // [RULE_08]

  // ---------------- capture qualification ----------------
  logic                  storeWrite_ff;   // entry write pulse
  logic                  nxt_storeWrite;  // next entry write
  logic [BUS_ADDR_W-1:0] storeAddr_ff;    // entry address
  logic [BUS_ADDR_W-1:0] nxt_storeAddr;   // next entry address
  logic [BUS_ADDR_W-1:0] lastAddr_ff;     // last stored address
  logic [BUS_ADDR_W-1:0] nxt_lastAddr;    // next last stored
  logic                  lastValid_ff;    // last stored address is valid
  logic                  nxt_lastValid;   // next last valid
  logic [BUS_ADDR_W-1:0] profile_ff;      // last executed address
  logic [BUS_ADDR_W-1:0] nxt_profile;     // next last executed
  logic                  breakReq_ff;     // break request pulse
  logic                  nxt_breakReq;    // next break request
  logic                  qualify;         // cycle qualifies for storage

  // pick qualifying cycles for the selected mode
  // limitation: dedup keeps one entry of history, so a loop over two
  // alternating targets is still stored in full
  always_comb begin
    qualify = 1'b0;
    unique case (ctrlView.captureMode)
      CAP_NORMAL:  qualify = busIsFlow;
      // history from before an arming write is stale and never blocks
      CAP_DEDUP:   qualify = busIsFlow && !(lastValid_ff && !countClear_ff
                           && busAddr == lastAddr_ff);        // [RULE_12]
      CAP_DETAIL:  qualify = !busIsFetch && !busIsFree;       // [RULE_13]
      CAP_PROFILE: qualify = 1'b0; // polled, nothing stored
    endcase
    qualify = qualify && busValid && ctrlView.armed;          // [RULE_05]
  end

  // next values of the capture and break state
  always_comb begin
    nxt_storeWrite = qualify;
    nxt_storeAddr  = qualify ? busAddr : storeAddr_ff;
    nxt_lastAddr   = qualify ? busAddr : lastAddr_ff;
    nxt_lastValid  = lastValid_ff || qualify;
    if (countClear_ff) begin
      // a new session must not compare against stale history, but an
      // entry stored in the clearing cycle itself still counts
      nxt_lastValid = qualify;
    end
    // only traced instructions update it, so a poll after the mode is
    // left still shows the last one seen in trace mode
    nxt_profile = profile_ff;
    if (retireValid && active) begin
      nxt_profile = retireAddr;                               // [RULE_14]
    end
    // registered so the request towards the cpu never glitches
    nxt_breakReq = sessionDone && ctrlView.breakEnable;       // [RULE_10]
  end

  // register the capture and break state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      storeWrite_ff <= 1'b0;
      storeAddr_ff  <= '0;
      lastAddr_ff   <= '0;
      lastValid_ff  <= 1'b0;
      profile_ff    <= '0;
      breakReq_ff   <= 1'b0;
    end else begin
      storeWrite_ff <= nxt_storeWrite;
      storeAddr_ff  <= nxt_storeAddr;
      lastAddr_ff   <= nxt_lastAddr;
      lastValid_ff  <= nxt_lastValid;
      profile_ff    <= nxt_profile;
      breakReq_ff   <= nxt_breakReq;
    end
  end

  assign storeWrite      = storeWrite_ff;
  assign storeAddr       = storeAddr_ff;
  assign profileAddr     = profile_ff;
  assign cpuBreakRequest = breakReq_ff;

  // ---------------- assertions ----------------
  // the checks watch the stored byte and the capture pulses
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_legacy_write_block: assert property ( // [RULE_02]
    (wrAccess && legacyBreakpointEnable && !sessionDone)
      |=> $stable(ctrl_ff))
    else $error("control changed while legacy mode enabled");

  a_inactive_view_off: assert property ( // [RULE_01]
    !active |-> (!ctrlView.armed && !ctrlView.breakEnable
                 && ctrlView.captureMode == CAP_NORMAL))
    else $error("control fields act outside trace mode");

  a_secure_no_enable: assert property ( // [RULE_04]
    (secureMode && !ctrl_ff[EN_BIT]) |=> !ctrl_ff[EN_BIT])
    else $error("enable set in secure mode");

  a_arm_needs_enable: assert property ( // [RULE_06]
    ctrl_ff[ARM_BIT] |-> ctrl_ff[EN_BIT])
    else $error("armed without enable");

  a_armed_lock_fields: assert property ( // [RULE_15]
    ctrl_ff[ARM_BIT] |=> ((ctrl_ff & ~ARMED_MASK)
                          == ($past(ctrl_ff) & ~ARMED_MASK)))
    else $error("locked field changed while armed");

  a_arm_clears_count: assert property ( // [RULE_16]
    (wrAllowed && wbyte[EN_BIT] && wbyte[ARM_BIT] && !secureMode)
      |=> countClear ##1 !countClear)
    else $error("arming did not pulse count clear");

  a_reserved_zero: assert property ( // [RULE_17]
    ((ctrl_ff | rdata_ff[CTRL_W-1:0]) & ~DEFINED_MASK) == '0)
    else $error("reserved bit not zero");

  a_detail_no_fetch: assert property ( // [RULE_13]
    (ctrlView.captureMode == CAP_DETAIL && busValid
     && (busIsFetch || busIsFree)) |=> !storeWrite)
    else $error("fetch or free cycle stored in detail mode");

  a_dedup_repeat: assert property ( // [RULE_12]
    (storeWrite && ctrlView.captureMode == CAP_DEDUP
     && $stable(ctrlView.captureMode) && busValid && busIsFlow
     && busAddr == storeAddr && !countClear_ff) |=> !storeWrite)
    else $error("duplicate entry stored in dedup mode");

  a_break_follows: assert property ( // [RULE_10]
    cpuBreakRequest |-> $past(sessionDone) && $past(ctrlView.breakEnable))
    else $error("break request without completed session");

  a_profile_tracks: assert property ( // [RULE_14]
    (retireValid && active) |=> profileAddr == $past(retireAddr))
    else $error("profile address not updated");

  a_lone_arm_refused: assert property ( // [RULE_06]
    (wrAllowed && !wbyte[EN_BIT]) |=> !ctrl_ff[ARM_BIT])
    else $error("arm set by a write without enable");

  a_unarmed_no_store: assert property ( // [RULE_05]
    !ctrlView.armed |=> !storeWrite)
    else $error("entry stored while unarmed");

  a_profile_no_store: assert property ( // [RULE_11]
    (ctrlView.captureMode == CAP_PROFILE) |=> !storeWrite)
    else $error("entry stored in profile mode");

  a_store_addr_taken: assert property ( // [RULE_11]
    storeWrite |-> storeAddr == $past(busAddr))
    else $error("stored address is not the bus address");

  c_arm_write: cover property (wrAllowed && wantArm);
  c_secure_refuse: cover property (wrAllowed && wbyte[EN_BIT] && secureMode);
  c_dedup_store: cover property (
    storeWrite && ctrlView.captureMode == CAP_DEDUP);
  c_break_pulse: cover property (cpuBreakRequest);
  c_detail_store: cover property (
    storeWrite && ctrlView.captureMode == CAP_DETAIL);

endmodule // trace_debug_control_reg

//--- trace_debug_control_reg_test.sv
// self-checking bench for the trace debug control register
`timescale 1ns/1ns
module trace_debug_control_reg_test
  import trace_debug_pkg::*;
;
  // one compare: counts it, reports a mismatch at once
  `define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    failCount++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end end

  logic                  clk_sys;                // 20 MHz system clock
  logic                  rst;                    // async reset, high
  apb_req_t              apbReq;                 // bus request
  apb_rsp_t              apbRsp;                 // bus answer
  logic                  legacyBreakpointEnable; // blocks writes
  logic                  secureMode;             // chip secured
  logic                  sessionDone;            // session end pulse
  logic                  busValid;               // traced bus cycle
  logic                  busIsFetch;             // program fetch
  logic                  busIsFree;              // free cycle
  logic                  busIsFlow;              // change-of-flow fetch
  logic [BUS_ADDR_W-1:0] busAddr;                // traced address
  logic                  retireValid;            // instruction done
  logic [BUS_ADDR_W-1:0] retireAddr;             // its address
  ctrl_view_t            ctrlView;               // effective controls
  logic                  otherRegsLocked;        // lock while armed
  logic                  countClear;             // word count clear
  logic                  storeWrite;             // capture strobe
  logic [BUS_ADDR_W-1:0] storeAddr;              // captured address
  logic [BUS_ADDR_W-1:0] profileAddr;            // last executed
  logic                  cpuBreakRequest;        // break pulse
  logic                  breakTagged;            // break kind
  int                    failCount = 0;          // mismatches
  int                    checks = 0;             // compares made

  trace_debug_control_reg trace_debug_control_reg_i (.clk_sys(clk_sys),
    .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .legacyBreakpointEnable(legacyBreakpointEnable),
    .secureMode(secureMode), .sessionDone(sessionDone),
    .busValid(busValid), .busIsFetch(busIsFetch), .busIsFree(busIsFree),
    .busIsFlow(busIsFlow), .busAddr(busAddr), .retireValid(retireValid),
    .retireAddr(retireAddr), .ctrlView(ctrlView),
    .otherRegsLocked(otherRegsLocked), .countClear(countClear),
    .storeWrite(storeWrite), .storeAddr(storeAddr),
    .profileAddr(profileAddr), .cpuBreakRequest(cpuBreakRequest),
    .breakTagged(breakTagged));

  // free running clock, 50 ns period
  always #25 clk_sys = ~clk_sys;

  // verdict and the single exit point
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; pready, read data and error taken at the same edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, wr, a, {24'h000000, wd}};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge clk_sys);
      if (apbRsp.pready === 1'b1) break;
    end
    if (n == 8) begin
      failCount++;
      end_of_test();
    end
    rd = apbRsp.prdata;
    er = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  // control write and checked control read
  task automatic wr8(input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, CTRL_OFFSET, d, r, e);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] e);
    logic [31:0] r;
    logic        er;
    apb(1'b0, CTRL_OFFSET, 8'h00, r, er);
    `CHK(nm, {24'h000000, e}, r)
  endtask

  // one-cycle session end pulse, break expectation one cycle later
  task automatic end_session(input logic brk);
    @(posedge clk_sys);
    sessionDone <= 1'b1;
    @(posedge clk_sys);
    sessionDone <= 1'b0;
    @(negedge clk_sys);
    `CHK("breakPulse", brk, cpuBreakRequest)
    `CHK("disarmed", 1'b0, ctrlView.armed)
    @(negedge clk_sys);
    `CHK("breakEnd", 1'b0, cpuBreakRequest)
  endtask

  // reset value, unmapped address refused with an error
  task automatic t_reset_map();
    logic [31:0] r;
    logic        e;
    rd_chk("resetValue", 8'h00);
    apb(1'b1, 12'h024, 8'hff, r, e);
    `CHK("unmappedErr", 1'b1, e)
    rd_chk("afterUnmapped", 8'h00);
  endtask

  // field writes while unarmed; bit 2 dropped, lone arm refused
  task automatic t_fields();
    wr8(8'h3f);
    rd_chk("bit2Dropped", 8'h3b);
    `CHK("viewOff", ctrl_view_t'(0), ctrlView)
    wr8(8'h7f);
    rd_chk("loneArm", 8'h3b);
    wr8(8'hbb);
    rd_chk("enabled", 8'hbb);
    `CHK("view", {5'b10111, CAP_PROFILE}, ctrlView)
    `CHK("tagBreak", 1'b1, breakTagged)
    wr8(8'h98);
    @(negedge clk_sys);
    `CHK("view2", {5'b10011, CAP_NORMAL}, ctrlView)
    `CHK("matchBreak", 1'b0, breakTagged)
  endtask

  // legacy breakpoint blocks writes and hides the controls
  task automatic t_legacy();
    @(posedge clk_sys);
    legacyBreakpointEnable <= 1'b1;
    wr8(8'h00);
    rd_chk("legacyHeld", 8'h98);
    `CHK("legacyOff", 1'b0, ctrlView.traceActive)
    legacyBreakpointEnable <= 1'b0;
    @(posedge clk_sys);
    secureMode <= 1'b1;
    wr8(8'hc3);
    rd_chk("secureRefused", 8'h03);
    secureMode <= 1'b0;
  endtask

  // arming clears the count, locks the other bits, session end breaks
  task automatic t_arm();
    wr8(8'he9);
    @(negedge clk_sys);
    `CHK("countClear", 1'b1, countClear)
    `CHK("locked", 1'b1, otherRegsLocked)
    @(negedge clk_sys);
    `CHK("clearPulse", 1'b0, countClear)
    wr8(8'hc2);
    rd_chk("lockedBits", 8'he9);
    wr8(8'h02);
    rd_chk("disarmWrite", 8'h29);
    wr8(8'hed);
    rd_chk("rearmOnly", 8'he9);
    end_session(1'b1);
  endtask

  // every capture mode over fetch, repeated fetch, data and free cycles
  task automatic t_modes();
    logic [15:0] adr [4] = '{16'h1111, 16'h1111, 16'h2222, 16'h3333};
    int          expN [4] = '{2, 1, 1, 0};
    logic [15:0] expA [4] = '{16'h1111, 16'h1111, 16'h2222, 16'h0000};
    logic [15:0] last;
    int          n;
    for (int m = 0; m < 4; m++) begin
      wr8({6'b110000, m[1:0]});
      n = 0;
      last = 16'h0000;
      for (int k = 0; k < 5; k++) begin
        @(posedge clk_sys);
        busValid <= (k < 4);
        busIsFetch <= (k < 2);
        busIsFlow <= (k < 2);
        busIsFree <= (k == 3);
        busAddr <= adr[k % 4];
        retireValid <= (k == 0);
        retireAddr <= 16'h4a50 + 16'(m);
        @(negedge clk_sys);
        if (storeWrite === 1'b1) begin
          n++;
          last = storeAddr;
        end
      end
      `CHK("storeCount", expN[m], n)
      `CHK("storeAddr", expA[m], last)
      `CHK("profile", 16'h4a50 + 16'(m), profileAddr)
      end_session(1'b0);
    end
  endtask

  // reset, then the scenarios in order
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    apbReq = '0;
    {legacyBreakpointEnable, secureMode, sessionDone} = 3'b000;
    {busValid, busIsFetch, busIsFree, busIsFlow, retireValid} = 5'h00;
    busAddr = 16'h0000;
    retireAddr = 16'h0000;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset_map();
    t_fields();
    t_legacy();
    t_arm();
    t_modes();
    end_of_test();
  end
endmodule // trace_debug_control_reg_test
